// ===== src/fms_pkg.sv
// Constants and types shared by the fail mode supervisor
package fms_pkg;

    // Channel and input counts
    localparam int NUM_CH    = 5;                      // Power channels
    localparam int NUM_FAULT = 8;                      // Reported fault kinds
    localparam int SYNC_W    = 5 + NUM_CH + NUM_FAULT; // Synchronised pin vector

    // Positions inside the synchronised pin vector
    localparam int SY_WAKE = 0;          // Wake condition
    localparam int SY_RSTP = 1;          // Active low reset pin
    localparam int SY_LIMP = 2;          // Fail mode pin
    localparam int SY_BAT  = 3;          // Battery above its reset level
    localparam int SY_VCC  = 4;          // Logic supply above its reset level
    localparam int SY_DIR  = 5;          // First direct channel input
    localparam int SY_FLT  = SY_DIR + NUM_CH; // First fault input

    // Serial frame layout
    localparam int FRAME_BITS   = 16;    // Frame length must be a multiple of this
    localparam int LEN_CHK_W    = 4;     // Low count bits for the length check
    localparam int CNT_W        = 16;    // Free running link bit counter width
    localparam int RX_WD_BIT    = 15;    // Watchdog toggle bit in received word
    localparam int RX_EXT_BIT   = 5;     // External switch control setting

    // Device status register number 7 as returned on the serial output
    localparam int         ST_ADDR_LSB = 12;      // Register number field
    localparam logic [3:0] ST_ADDR     = 4'h7;    // Register number value
    localparam int         ST_LIMP_BIT = 11;      // Fail mode pin level
    localparam int         ST_FLAG_BIT = 10;      // Serial failure flag
    localparam int         ST_FAIL_BIT = 9;       // Device is in fail mode
    localparam int         ST_BAT_BIT  = 8;       // Battery present
    localparam int         ST_FLT_LSB  = 0;       // Fault kinds

    // Reset values
    localparam logic [15:0] TX_RST   = 16'h0000; // Status word after reset
    localparam logic        WD_RST   = 1'b0;     // Held toggle bit after reset
    localparam logic        FLAG_RST = 1'b0;     // Serial failure flag after reset

    // Watchdog timing
    localparam int WD_TIMEOUT_US  = 32000;                       // Timeout in us
    localparam int SYS_CLK_MHZ    = 200;                         // System clock rate
    localparam int WD_TIMEOUT_CYC = WD_TIMEOUT_US * SYS_CLK_MHZ; // Timeout in cycles
    localparam int WD_CNT_W       = 23;                          // Timeout counter width

    // Operating modes
    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_SLEEP,
        MODE_NORMAL,
        MODE_FAIL
    } fms_mode_e;

endpackage

// ===== src/fms_supervisor.sv
// Mode selection, serial watchdog and supply supervision of the high side switch

// Overview of operation
// R1: Operate while wake is high, otherwise sit in sleep with outputs off.
// R2: Serial output drives only while the logic supply is present.
// R3: While the reset pin is low, the clock pin reports wake state.
// R4: Awake with reset pin low drives clock pin high, else it stays input.
// R5: Both supplies lost: power off, all outputs off, all state cleared.
// R6: Battery lost alone: keep state, channels off, external switch keeps setting.
// R7: Battery lost: no wake report on clock pin, serial stays usable.
// R8: Logic supply lost: frames ignored, watchdog times out into a fault.
// R9: Normal mode drives channels from the PWM engine configured serially.
// R10: Status word reports the eight fault kinds.
// R11: Direct channel control only in fail mode; pin forces it without logic supply.
// R12: Fail mode pin high puts the device into fail mode.
// R13: In fail mode each channel follows its direct input.
// R14: Fail mode pin level readable in status register seven.
// R15: Any serial communication fault switches to fail mode.
// R16: Frame without toggled watchdog bit is a communication fault.
// R17: No valid frame before the watchdog timeout is a communication fault.
// R18: Frame bit count not a multiple of sixteen is a communication fault.
// R19: Stuck serial input shows up as a watchdog toggle error.
// R20: Fault sets the failure flag, reported in the next frame.
// R21: Failure flag holds while the device stays in fail mode.
// R22: Failure flag clears on the step from fail to normal mode.
// R23: Watchdog bit compared with the held one, held value updated each frame.
module fms_supervisor
    import fms_pkg::*;
#(
    parameter int WD_CYCLES = WD_TIMEOUT_CYC                  // Watchdog timeout in cycles
) (
    input  wire logic              sys_clk_in,                // System clock, 200 MHz
    input  wire logic              rst_n_in,                  // Synchronous reset, active low
    input  wire logic              wake_in,                   // Wake condition pin
    input  wire logic              active_low_reset_pin_n_in, // Reset pin, active low
    input  wire logic              fail_mode_pin_in,          // Fail mode request pin
    input  wire logic              battery_ok_in,             // Battery above reset level
    input  wire logic              logic_supply_ok_in,        // Logic supply above reset level
    input  wire logic [NUM_CH-1:0] direct_channel_input_in,   // Direct channel pins
    input  wire logic [NUM_FAULT-1:0] fault_in,               // Fault kinds from diagnostics
    input  wire logic [NUM_CH-1:0] pwm_channel_in,            // PWM engine channel drive
    input  wire logic              spi_sclk_in,               // Serial clock, link domain
    input  wire logic              spi_cs_n_in,               // Chip select, active low
    input  wire logic              spi_mosi_in,               // Serial data in
    output logic                   spi_miso_out,              // Serial data out
    output logic                   spi_miso_oe_out,           // Serial data out enable
    output logic                   clk_pin_out,               // Clock pin output level
    output logic                   clk_pin_oe_out,            // Clock pin output enable
    output logic [NUM_CH-1:0]      power_channel_output_out,  // Power channel drive
    output logic                   external_switch_control_output_out, // External switch drive
    output logic                   fail_mode_out,             // Fail mode active
    output logic                   sleep_mode_out,            // Sleep mode active
    output logic                   serial_failure_flag_out,   // Serial failure flag
    output logic [15:0]            cfg_word_out,              // Last accepted frame word
    output logic                   cfg_valid_out              // Pulse on accepted frame
);

    logic [SYNC_W-1:0]    async_vec;
    logic [SYNC_W-1:0]    sy1_q;
    logic [SYNC_W-1:0]    sy2_q;
    logic [SYNC_W-1:0]    sy3_q;
    logic [SYNC_W-1:0]    pin_q;
    logic                 cs1_q;
    logic                 cs2_q;
    logic                 cs3_q;
    logic                 cs_stab_q;
    logic                 cs_prev_q;
    logic                 link_rst_n_q;
    logic [CNT_W-1:0]     link_cnt_q;
    logic [15:0]          link_shift_q;
    logic [CNT_W-1:0]     last_cnt_q;
    logic [CNT_W-1:0]     frame_len;
    logic [LEN_CHK_W-1:0] bit_idx;
    logic [15:0]          tx_q;
    logic [15:0]          tx_d;
    logic                 wd_held_q;
    logic [WD_CNT_W-1:0]  wd_cnt_q;
    logic                 comm_fail_q;
    logic                 comm_fail_d;
    logic                 flag_q;
    logic                 ext_cfg_q;
    fms_mode_e            mode_q;
    fms_mode_e            mode_d;
    logic                 awake;
    logic                 bat_ok;
    logic                 vcc_ok;
    logic                 limp;
    logic                 power_off;
    logic                 frame_end;
    logic                 frame_evt;
    logic                 len_err;
    logic                 wd_err;
    logic                 frame_ok;
    logic                 timeout_hit;
    logic                 fault_evt;

    // Pack every asynchronous pin except the serial link pins into one vector
    assign async_vec = {fault_in, direct_channel_input_in, logic_supply_ok_in, battery_ok_in,
                        fail_mode_pin_in, active_low_reset_pin_n_in, wake_in};

    // Three stage synchronisers; a change counts once stages two and three agree
    for (genvar gi = 0; gi < SYNC_W; gi++) begin : g_sync
        always_ff @(posedge sys_clk_in) begin
            if (!rst_n_in) begin
                sy1_q[gi] <= 1'b0;
                sy2_q[gi] <= 1'b0;
                sy3_q[gi] <= 1'b0;
                pin_q[gi] <= 1'b0;
            end else begin
                sy1_q[gi] <= async_vec[gi];
                sy2_q[gi] <= sy1_q[gi];
                sy3_q[gi] <= sy2_q[gi];
                if (sy2_q[gi] == sy3_q[gi]) begin
                    pin_q[gi] <= sy2_q[gi];
                end
            end
        end
    end

    // Filtered pin levels
    assign awake     = pin_q[SY_WAKE];
    assign bat_ok    = pin_q[SY_BAT];
    assign vcc_ok    = pin_q[SY_VCC];
    assign limp      = pin_q[SY_LIMP];
    assign power_off = !bat_ok && !vcc_ok; // [R5]

    // Chip select synchroniser and stable level; idles high
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            cs1_q     <= 1'b1;
            cs2_q     <= 1'b1;
            cs3_q     <= 1'b1;
            cs_stab_q <= 1'b1;
            cs_prev_q <= 1'b1;
        end else begin
            cs1_q     <= spi_cs_n_in;
            cs2_q     <= cs1_q;
            cs3_q     <= cs2_q;
            if (cs2_q == cs3_q) begin
                cs_stab_q <= cs2_q;
            end
            cs_prev_q <= cs_stab_q;
        end
    end

    // Frame ends when the stable chip select rises
    assign frame_end = cs_stab_q && !cs_prev_q;

    // Link domain reset, held by system reset and by power off
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            link_rst_n_q <= 1'b0;
        end else begin
            link_rst_n_q <= !power_off; // [R5]
        end
    end

    // Link side: free running bit counter and receive shifter on the serial clock
    always_ff @(posedge spi_sclk_in or negedge link_rst_n_q) begin
        if (!link_rst_n_q) begin
            link_cnt_q   <= '0;
            link_shift_q <= '0;
        end else if (!spi_cs_n_in) begin
            link_cnt_q   <= link_cnt_q + 1'b1;
            link_shift_q <= {link_shift_q[14:0], spi_mosi_in};
        end
    end

    // Bits clocked since the last frame; counter and shifter are still once the clock stops
    assign frame_len = link_cnt_q - last_cnt_q;
    assign bit_idx   = frame_len[LEN_CHK_W-1:0];

    // Status word goes out MSB first, stable while the chip select is low
    assign spi_miso_out    = tx_q[~bit_idx];
    assign spi_miso_oe_out = !spi_cs_n_in && vcc_ok; // [R2]

    // Frame checks evaluated when a frame closes
    assign len_err   = (bit_idx != '0) || (frame_len == '0); // [R18]
    assign wd_err    = (link_shift_q[RX_WD_BIT] == wd_held_q); // [R16] [R19] [R23]
    assign frame_evt = frame_end && vcc_ok;                    // [R8]
    assign frame_ok  = frame_evt && !len_err && !wd_err;
    assign timeout_hit = awake && !frame_ok && (wd_cnt_q == WD_CNT_W'(WD_CYCLES - 1)); // [R17]
    assign fault_evt = (frame_evt && (len_err || wd_err)) || timeout_hit;

    // Bit count reference and held watchdog bit, updated on every compared frame
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || power_off) begin
            last_cnt_q <= '0;
            wd_held_q  <= WD_RST;
        end else if (frame_end) begin
            last_cnt_q <= link_cnt_q;
            if (frame_evt) begin
                wd_held_q <= link_shift_q[RX_WD_BIT]; // [R23]
            end
        end
    end

    // Watchdog timer restarted by every valid frame
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || power_off || !awake || frame_ok || timeout_hit) begin
            wd_cnt_q <= '0;
        end else begin
            wd_cnt_q <= wd_cnt_q + 1'b1; // [R8] [R17]
        end
    end

    // Accepted frame word towards the PWM engine
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || power_off) begin
            cfg_word_out  <= '0;
            cfg_valid_out <= 1'b0;
            ext_cfg_q     <= 1'b0;
        end else begin
            cfg_valid_out <= frame_ok; // [R9]
            if (frame_ok) begin
                cfg_word_out <= link_shift_q;
                ext_cfg_q    <= link_shift_q[RX_EXT_BIT];
            end
        end
    end

    // Communication fault latch; a fault wins over a good frame in the same cycle
    always_comb begin
        comm_fail_d = comm_fail_q;
        if (fault_evt) begin
            comm_fail_d = 1'b1; // [R15]
        end else if (frame_ok) begin
            comm_fail_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || power_off) begin
            comm_fail_q <= 1'b0;
        end else begin
            comm_fail_q <= comm_fail_d;
        end
    end

    // Mode selection
    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            MODE_OFF, MODE_SLEEP, MODE_NORMAL, MODE_FAIL: begin
                if (power_off) begin
                    mode_d = MODE_OFF; // [R5]
                end else if (!awake) begin
                    mode_d = MODE_SLEEP; // [R1]
                end else if (limp || comm_fail_d) begin
                    mode_d = MODE_FAIL; // [R11] [R12] [R15]
                end else begin
                    mode_d = MODE_NORMAL;
                end
            end
            default: begin
                mode_d = MODE_OFF;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            mode_q <= MODE_OFF;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Serial failure flag: set by a fault, held in fail mode, cleared on return to normal
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || power_off) begin
            flag_q <= FLAG_RST;
        end else if (fault_evt) begin
            flag_q <= 1'b1; // [R20]
        end else if (mode_q == MODE_FAIL && mode_d == MODE_NORMAL) begin
            flag_q <= 1'b0; // [R22]
        end
    end

    // Status register seven image, refreshed only between frames
    always_comb begin
        tx_d                          = TX_RST;
        tx_d[ST_ADDR_LSB +: 4]        = ST_ADDR;
        tx_d[ST_LIMP_BIT]             = limp; // [R14]
        tx_d[ST_FLAG_BIT]             = flag_q; // [R20]
        tx_d[ST_FAIL_BIT]             = (mode_q == MODE_FAIL);
        tx_d[ST_BAT_BIT]              = bat_ok;
        tx_d[ST_FLT_LSB +: NUM_FAULT] = pin_q[SY_FLT +: NUM_FAULT]; // [R10]
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || power_off) begin
            tx_q <= TX_RST;
        end else if (cs_stab_q && cs2_q) begin
            tx_q <= tx_d;
        end
    end

    // Channel and external switch drive per mode
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            power_channel_output_out           <= '0;
            external_switch_control_output_out <= 1'b0;
        end else begin
            power_channel_output_out           <= '0; // [R5] [R6] [R1]
            external_switch_control_output_out <= 1'b0;
            case (mode_q)
                MODE_NORMAL: begin
                    if (bat_ok) begin
                        power_channel_output_out <= pwm_channel_in; // [R9]
                    end
                    external_switch_control_output_out <= ext_cfg_q && vcc_ok; // [R6]
                end
                MODE_FAIL: begin
                    if (bat_ok) begin
                        power_channel_output_out <= pin_q[SY_DIR +: NUM_CH]; // [R13] [R11]
                    end
                end
                default: begin
                    power_channel_output_out <= '0;
                end
            endcase
        end
    end

    // Wake reporting on the clock pin and mode indications
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            clk_pin_out             <= 1'b0;
            clk_pin_oe_out          <= 1'b0;
            fail_mode_out           <= 1'b0;
            sleep_mode_out          <= 1'b0;
            serial_failure_flag_out <= FLAG_RST;
        end else begin
            clk_pin_out             <= 1'b1; // [R4]
            clk_pin_oe_out          <= awake && !pin_q[SY_RSTP] && bat_ok && !power_off; // [R3] [R4] [R7]
            fail_mode_out           <= (mode_q == MODE_FAIL);
            sleep_mode_out          <= (mode_q == MODE_SLEEP); // [R1]
            serial_failure_flag_out <= flag_q;
        end
    end

    // Checks on the system domain
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_pin_forces_fail: assert property ((limp && awake && !power_off) |-> ##[1:2] fail_mode_out) // [R12]
        else $error("fail pin did not force fail mode");

    a_fail_follows_direct: assert property ((mode_q == MODE_FAIL && bat_ok)
        |=> power_channel_output_out == $past(pin_q[SY_DIR +: NUM_CH])) // [R13]
        else $error("channels did not follow direct inputs");

    a_normal_uses_pwm: assert property ((mode_q == MODE_NORMAL && bat_ok)
        |=> power_channel_output_out == $past(pwm_channel_in)) // [R9]
        else $error("channels did not follow the PWM engine");

    a_battery_loss_off: assert property ((!bat_ok && vcc_ok) |=> power_channel_output_out == '0) // [R6]
        else $error("channels on without battery");

    a_power_off_clears: assert property (power_off |=> (!flag_q && !comm_fail_q && power_channel_output_out == '0
        && !external_switch_control_output_out)) // [R5]
        else $error("power off left state behind");

    a_fault_sets_flag: assert property (fault_evt |=> (flag_q && comm_fail_q) ##1 fail_mode_out) // [R15]
        else $error("fault did not enter fail mode");

    a_length_error: assert property ((frame_evt && bit_idx != '0) |-> fault_evt) // [R18]
        else $error("bad frame length not flagged");

    a_toggle_error: assert property ((frame_evt && link_shift_q[RX_WD_BIT] == wd_held_q) |=> comm_fail_q) // [R16]
        else $error("untoggled watchdog bit not flagged");

    a_timeout_fault: assert property ((awake && !frame_ok && wd_cnt_q == WD_CNT_W'(WD_CYCLES - 1) && !power_off)
        |=> comm_fail_q && wd_cnt_q == '0) // [R17]
        else $error("watchdog timeout not flagged");

    a_flag_holds_fail: assert property ((flag_q && mode_q == MODE_FAIL && mode_d == MODE_FAIL && !power_off)
        |=> flag_q) // [R21]
        else $error("flag dropped while in fail mode");

    a_flag_clears_exit: assert property ((mode_q == MODE_FAIL && mode_d == MODE_NORMAL && !fault_evt)
        |=> !flag_q) // [R22]
        else $error("flag kept after return to normal");

    a_sleep_off: assert property ((!awake && !power_off) |=> ##1 (sleep_mode_out && power_channel_output_out == '0)) // [R1]
        else $error("outputs on during sleep");

    a_clk_report: assert property ((awake && !pin_q[SY_RSTP] && bat_ok && !power_off) |=> clk_pin_oe_out && clk_pin_out
        ) // [R3]
        else $error("wake state not reported on clock pin");

    a_no_report_bat: assert property (!bat_ok |=> !clk_pin_oe_out) // [R7]
        else $error("wake reported without battery");

    a_miso_needs_vcc: assert property (!vcc_ok |-> !spi_miso_oe_out) // [R2]
        else $error("serial output driven without logic supply");

    a_status_limp: assert property ((cs_stab_q && cs2_q && !power_off) |=> tx_q[ST_LIMP_BIT] == $past(limp)) // [R14]
        else $error("status word lost fail pin level");

endmodule

// ===== testbench/fms_mcu_model.sv
// Microcontroller model that clocks frames into the supervisor's serial port
module fms_mcu_model (
    output logic      sclk_out, // Link clock, still between frames
    output logic      cs_n_out, // Chip select, active low
    output logic      mosi_out, // Serial data to the device
    input  wire logic miso_in   // Settled serial data from the device
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle levels of the link
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    // One frame MSB first at a 48 ns link period; the caller picks toggle bit and length
    task automatic xfer(input int nbits, input logic [15:0] word, output logic [15:0] rx);
        cs_n_out = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            mosi_out = word[i % 16];
            #24 sclk_out = 1'b1;
            rx = {rx[14:0], miso_in};
            #24 sclk_out = 1'b0;
        end
        #24 cs_n_out = 1'b1;
        mosi_out = ~mosi_out; // Released data line shows no stale value
        #100;
    endtask
endmodule

// ===== testbench/fms_supervisor_tb.sv
// Self-checking bench for the fail mode supervisor
module fms_supervisor_tb
    import fms_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in, rst_n_in, wake_in, active_low_reset_pin_n_in, fail_mode_pin_in, wd;
    logic battery_ok_in, logic_supply_ok_in, spi_sclk_in, spi_cs_n_in, spi_mosi_in;
    logic [NUM_CH-1:0] direct_channel_input_in, pwm_channel_in, power_channel_output_out;
    logic [NUM_FAULT-1:0] fault_in;
    logic spi_miso_out, spi_miso_oe_out, clk_pin_out, clk_pin_oe_out, fail_mode_out, cfg_valid_out;
    logic external_switch_control_output_out, sleep_mode_out, serial_failure_flag_out;
    logic [15:0] cfg_word_out, rx;
    int err_total = 0, checked = 0;
    wire logic miso_line = spi_miso_oe_out ? spi_miso_out : ~spi_miso_out; // Undriven line shows no stale value
    // System clock, 200 MHz
    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    // Device under test with a short watchdog timeout
    fms_supervisor #(.WD_CYCLES(1000)) i_fms_supervisor (
        .sys_clk_in, .rst_n_in, .wake_in, .active_low_reset_pin_n_in, .fail_mode_pin_in,
        .battery_ok_in, .logic_supply_ok_in, .direct_channel_input_in, .fault_in, .pwm_channel_in,
        .spi_sclk_in, .spi_cs_n_in, .spi_mosi_in, .spi_miso_out, .spi_miso_oe_out, .clk_pin_out,
        .clk_pin_oe_out, .power_channel_output_out, .external_switch_control_output_out,
        .fail_mode_out, .sleep_mode_out, .serial_failure_flag_out, .cfg_word_out, .cfg_valid_out
    );
    fms_mcu_model i_fms_mcu_model (
        .sclk_out(spi_sclk_in), .cs_n_out(spi_cs_n_in), .mosi_out(spi_mosi_in), .miso_in(miso_line)
    );
    // Compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Wait up to n cycles for the mode output to reach v
    task automatic wait_fail(input logic v, input int n);
        for (int k = 0; k < n && fail_mode_out !== v; k++) begin
            @(posedge sys_clk_in);
            #1;
        end
        if (fail_mode_out !== v) begin
            err_total++;
            $display("unexpected at %0t ns: mode wait ran out", $time);
            stop_test();
        end
    endtask
    // Frame with the toggle bit inverted and the external switch bit set
    task automatic good();
        wd = ~wd;
        i_fms_mcu_model.xfer(16, {wd, 15'h0020}, rx);
    endtask
    task automatic recover();
        wd = 1'b0;
        good();
        good();
        wait_fail(1'b0, 12);
        chk(serial_failure_flag_out, 1'b0); // Flag cleared on return
    endtask
    task automatic t_toggle();
        good();
        chk(cfg_word_out, {wd, 15'h0020}); // Frame accepted
        chk(rx, {ST_ADDR, 4'b0001, 8'h5c}); // Status word
        chk(power_channel_output_out, pwm_channel_in); // PWM drives channels
        chk(external_switch_control_output_out, 1'b1); // Switch per setting
        i_fms_mcu_model.xfer(16, {wd, 15'h0020}, rx);
        wait_fail(1'b1, 12); // Untoggled bit
        chk(serial_failure_flag_out, 1'b1); // Flag set
        chk(power_channel_output_out, direct_channel_input_in); // Direct drive
        repeat (50) @(posedge sys_clk_in);
        chk(serial_failure_flag_out, 1'b1); // Flag held
        good();
        chk(rx, {ST_ADDR, 4'b0111, 8'h5c}); // Flag reported next frame
        wait_fail(1'b0, 12);
        repeat (2) @(posedge sys_clk_in);
        chk(serial_failure_flag_out, 1'b0); // Cleared on return
        $display("toggle test done");
    endtask
    task automatic t_length();
        i_fms_mcu_model.xfer(12, 16'h0020, rx);
        wait_fail(1'b1, 12); // Short frame
        chk(serial_failure_flag_out, 1'b1); // Flag set
        recover();
        $display("length test done");
    endtask
    task automatic t_limp();
        @(posedge sys_clk_in) fail_mode_pin_in <= 1'b1;
        wait_fail(1'b1, 8); // Pin forces fail mode
        chk(power_channel_output_out, direct_channel_input_in); // Direct drive
        good();
        chk(rx, {ST_ADDR, 4'b1011, 8'h5c}); // Pin level visible
        @(posedge sys_clk_in) fail_mode_pin_in <= 1'b0;
        wait_fail(1'b0, 8);
        chk(power_channel_output_out, pwm_channel_in); // No direct drive in normal mode
        $display("fail pin test done");
    endtask
    task automatic t_supply();
        @(posedge sys_clk_in) battery_ok_in <= 1'b0;
        repeat (8) @(posedge sys_clk_in);
        good();
        chk(rx[8], 1'b0); // Serial reporting kept
        chk(power_channel_output_out, 5'h00); // Channels off
        chk({fail_mode_out, external_switch_control_output_out}, 2'b01); // State kept
        chk(cfg_word_out, {wd, 15'h0020}); // Frames still taken
        @(posedge sys_clk_in) battery_ok_in <= 1'b1;
        @(posedge sys_clk_in) logic_supply_ok_in <= 1'b0;
        repeat (8) @(posedge sys_clk_in);
        fork
            good();
            #300 chk(spi_miso_oe_out, 1'b0); // No readback without logic supply
        join
        wait_fail(1'b1, 1200); // Watchdog runs out
        @(posedge sys_clk_in) logic_supply_ok_in <= 1'b1;
        repeat (8) @(posedge sys_clk_in);
        recover();
        $display("supply test done");
    endtask
    task automatic t_timeout();
        repeat (800) @(posedge sys_clk_in);
        chk(fail_mode_out, 1'b0); // Not before the timeout
        wait_fail(1'b1, 300); // Timeout fault
        chk(serial_failure_flag_out, 1'b1); // Flag set
        @(posedge sys_clk_in) {battery_ok_in, logic_supply_ok_in} <= 2'b00;
        repeat (8) @(posedge sys_clk_in);
        chk({power_channel_output_out, external_switch_control_output_out}, 6'h00); // All off
        chk(cfg_word_out, 16'h0000); // Registers cleared
        @(posedge sys_clk_in) {battery_ok_in, logic_supply_ok_in} <= 2'b11;
        repeat (8) @(posedge sys_clk_in);
        chk({fail_mode_out, serial_failure_flag_out}, 2'b00); // Faults cleared
        wd = 1'b0;
        $display("timeout and power off test done");
    endtask
    task automatic t_wake();
        @(posedge sys_clk_in) active_low_reset_pin_n_in <= 1'b0;
        repeat (8) @(posedge sys_clk_in);
        chk({clk_pin_oe_out, clk_pin_out}, 2'b11); // Wake reported
        @(posedge sys_clk_in) battery_ok_in <= 1'b0;
        repeat (8) @(posedge sys_clk_in);
        chk(clk_pin_oe_out, 1'b0); // No report without battery
        @(posedge sys_clk_in) {battery_ok_in, wake_in} <= 2'b10;
        repeat (8) @(posedge sys_clk_in);
        chk({sleep_mode_out, clk_pin_oe_out, power_channel_output_out}, 7'h40); // Sleep
        $display("wake test done");
    endtask
    // Reset, then the scenarios in turn
    initial begin
        {rst_n_in, wake_in, active_low_reset_pin_n_in, fail_mode_pin_in} = 4'b0110;
        {battery_ok_in, logic_supply_ok_in, wd} = 3'b110;
        direct_channel_input_in = 5'h0a;
        pwm_channel_in = 5'h15;
        fault_in = 8'h5c;
        repeat (4) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        repeat (20) @(posedge sys_clk_in);
        t_toggle();
        t_length();
        t_limp();
        t_supply();
        t_timeout();
        t_wake();
        stop_test();
    end
endmodule
